// file: hdl/i2c_front_pkg.sv
// Constants, codes and carrier types of the two-wire command front end.
// Assumes a system clock domain and a link clock domain, both reset by one async reset.
package i2c_front_pkg;

    localparam logic [7:0] DEVICE_RESET_CMD = 8'hf0;
    localparam logic [7:0] WRITE_CONFIG_CMD = 8'hd2;
    localparam logic [7:0] POINTER_SELECT_CMD = 8'he1;
    localparam logic [7:0] LINE_RESET_CMD = 8'hb4;
    localparam logic [7:0] LINE_WRITE_BYTE_CMD = 8'ha5;
    localparam logic [7:0] LINE_READ_BYTE_CMD = 8'h96;
    localparam logic [7:0] LINE_SINGLE_BIT_CMD = 8'h87;
    localparam logic [7:0] LINE_TRIPLET_CMD = 8'h78;

    localparam logic [7:0] CONFIG_PTR_CODE = 8'hc3;
    // Status and data pointer codes: arbitrary values
    localparam logic [7:0] STATUS_PTR_CODE_DEF = 8'h3c;
    localparam logic [7:0] DATA_PTR_CODE_DEF = 8'h1e;

    // Fixed upper slave address bits: arbitrary value
    localparam logic [4:0] SLAVE_ADDR_HI_DEF = 5'h06;

    localparam int BITS_PER_BYTE = 8;
    localparam logic [3:0] ACK_SLOT_CNT = 4'h8;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0] {L_IDLE, L_RX, L_RX_ACK, L_TX, L_TX_ACK, L_IGNORE} link_st_t;
    typedef enum logic [1:0] {PTR_STATUS, PTR_DATA, PTR_CONFIG} ptr_t;

    localparam ptr_t PTR_RESET = PTR_STATUS;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [7:0] param;
    } cmd_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] data;
        logic [7:0] config_val;
    } reg_view_t;

    function automatic logic is_line_cmd(input logic [7:0] c);
        return c == LINE_RESET_CMD || c == LINE_WRITE_BYTE_CMD || c == LINE_READ_BYTE_CMD ||
               c == LINE_SINGLE_BIT_CMD || c == LINE_TRIPLET_CMD;
    endfunction

    function automatic logic is_known_cmd(input logic [7:0] c);
        return is_line_cmd(c) || c == DEVICE_RESET_CMD || c == WRITE_CONFIG_CMD ||
               c == POINTER_SELECT_CMD;
    endfunction

    function automatic logic needs_param(input logic [7:0] c);
        return c == WRITE_CONFIG_CMD || c == POINTER_SELECT_CMD || c == LINE_WRITE_BYTE_CMD ||
               c == LINE_SINGLE_BIT_CMD || c == LINE_TRIPLET_CMD;
    endfunction

endpackage

// file: hdl/bit_sync.sv
// Multi-bit level synchroniser, each bit through its own flip-flop chain.
// Assumes each bit is an independent level or a toggle; no word coherence.
`timescale 1ns/1ps
module bit_sync
    import i2c_front_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    generate
        if (WIDTH < 1)
        begin : g_bad_width
            $error("bit_sync: WIDTH must be at least 1");
        end
    endgenerate

    always_comb
    begin
        next_s.meta = d_i;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            s <= '0;
        else
            s <= next_s;
    end

    assign q_o = s.stable;

endmodule // bit_sync

// file: hdl/i2c_command_front_end.sv
// Two-wire serial slave front end: bus conditions, addressing, command decode, read pointer.
// Assumes SCL/SDA are sampled on a free-running link clock well above the bus bit rate;
// register contents and line busy level come from the system clock domain.
`timescale 1ns/1ps

module i2c_command_front_end
    import i2c_front_pkg::*;
#(
    parameter logic [4:0] SLAVE_ADDR_HI = SLAVE_ADDR_HI_DEF,
    parameter logic [7:0] STATUS_PTR_CODE = STATUS_PTR_CODE_DEF,
    parameter logic [7:0] DATA_PTR_CODE = DATA_PTR_CODE_DEF
)
(
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic addr_select_pin_low_i,
    input wire logic addr_select_pin_high_i,
    input wire logic line_busy_flag_i,
    input wire reg_view_t regs_i,
    output cmd_t cmd_o,
    output logic bus_idle_o
);

    typedef struct packed {
        logic scl_q;
        logic sda_q;
        link_st_t st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic addr_phase;
        logic rw;
        logic [1:0] idx;
        logic [7:0] code;
        logic master_ack;
        ptr_t ptr;
        logic [7:0] iss_code;
        logic [7:0] iss_param;
        logic cmd_tgl;
        logic rd_req_tgl;
        logic sda_oe;
        logic sda_out;
        logic scl_oe;
        logic scl_out;
        logic idle;
    } link_state_t;
    localparam link_state_t LINK_RESET = '{scl_q: 1'b1, sda_q: 1'b1, st: L_IDLE, ptr: PTR_RESET, default: '0};

    typedef struct packed {
        logic cmd_seen;
        logic rd_seen;
        logic [7:0] rd_byte;
        cmd_t cmd;
    } sys_state_t;

    link_state_t l;
    link_state_t next_l;
    sys_state_t s;
    sys_state_t next_s;

    logic [4:0] link_sync_q;
    logic [1:0] sys_sync_q;
    logic scl_s;
    logic sda_s;
    logic pin_hi_s;
    logic pin_lo_s;
    logic busy_s;
    logic cmd_tgl_s;
    logic rd_req_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    generate
        if (STATUS_PTR_CODE == DATA_PTR_CODE || STATUS_PTR_CODE == CONFIG_PTR_CODE ||
            DATA_PTR_CODE == CONFIG_PTR_CODE)
        begin : g_bad_ptr_codes
            $error("i2c_command_front_end: pointer codes must be distinct");
        end
    endgenerate

    // Pins and the busy level into the link domain
    bit_sync #(
        .WIDTH(5)
    ) u_link_sync (
        .clk_i(link_clk_i),
        .arst_n_i(arst_n_i),
        .d_i({scl_i, sda_i, addr_select_pin_high_i, addr_select_pin_low_i, line_busy_flag_i}),
        .q_o(link_sync_q)
    );

    // Command and read-request toggles into the system domain
    bit_sync #(
        .WIDTH(2)
    ) u_sys_sync (
        .clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .d_i({l.cmd_tgl, l.rd_req_tgl}),
        .q_o(sys_sync_q)
    );

    assign {scl_s, sda_s, pin_hi_s, pin_lo_s, busy_s} = link_sync_q;
    assign {cmd_tgl_s, rd_req_s} = sys_sync_q;

    assign scl_rise = scl_s & ~l.scl_q;
    assign scl_fall = ~scl_s & l.scl_q;
    assign start_det = scl_s & l.scl_q & l.sda_q & ~sda_s;
    assign stop_det = scl_s & l.scl_q & ~l.sda_q & sda_s;

    function automatic logic ptr_code_valid(input logic [7:0] c);
        return c == STATUS_PTR_CODE || c == DATA_PTR_CODE || c == CONFIG_PTR_CODE;
    endfunction

    function automatic ptr_t ptr_from_code(input logic [7:0] c);
        ptr_t p;
        p = PTR_STATUS;
        if (c == DATA_PTR_CODE)
            p = PTR_DATA;
        else if (c == CONFIG_PTR_CODE)
            p = PTR_CONFIG;
        return p;
    endfunction

    // Link domain
    always_comb
    begin
        logic ack;
        logic addr_match;
        ack = 1'b0;
        addr_match = 1'b0;
        next_l = l;
        next_l.scl_q = scl_s;
        next_l.sda_q = sda_s;
        if (stop_det)
        begin
            next_l.st = L_IDLE;
            next_l.sda_oe = 1'b0;
            next_l.idle = 1'b1;
        end
        else if (start_det)
        begin
            // Start and repeated start both restart address reception
            next_l.st = L_RX;
            next_l.cnt = '0;
            next_l.addr_phase = 1'b1;
            next_l.sda_oe = 1'b0;
            next_l.idle = 1'b0;
        end
        else
        begin
            unique case (l.st)
                L_IDLE:
                begin
                    if (scl_s && sda_s)
                        next_l.idle = 1'b1;
                end
                L_RX:
                begin
                    if (scl_rise && l.cnt < ACK_SLOT_CNT)
                    begin
                        next_l.sh = {l.sh[6:0], sda_s};
                        next_l.cnt = l.cnt + 4'h1;
                    end
                    if (scl_fall && l.cnt == ACK_SLOT_CNT)
                    begin
                        next_l.cnt = '0;
                        if (l.addr_phase)
                        begin
                            addr_match = l.sh[7:3] == SLAVE_ADDR_HI &&
                                         l.sh[2:1] == {pin_hi_s, pin_lo_s};
                            ack = addr_match;
                            next_l.rw = l.sh[0];
                            next_l.idx = '0;
                            next_l.addr_phase = 1'b0;
                            if (addr_match && l.sh[0])
                                next_l.rd_req_tgl = ~l.rd_req_tgl;
                        end
                        else if (l.idx == 2'h0)
                        begin
                            next_l.code = l.sh;
                            next_l.idx = 2'h1;
                            ack = is_known_cmd(l.sh) && !(is_line_cmd(l.sh) && busy_s);
                            if (ack && !needs_param(l.sh))
                            begin
                                next_l.iss_code = l.sh;
                                next_l.iss_param = '0;
                                next_l.cmd_tgl = ~l.cmd_tgl;
                                next_l.ptr = PTR_STATUS;
                            end
                        end
                        else if (l.idx == 2'h1 && needs_param(l.code))
                        begin
                            next_l.idx = 2'h2;
                            if (l.code == POINTER_SELECT_CMD)
                            begin
                                ack = ptr_code_valid(l.sh);
                                if (ack)
                                    next_l.ptr = ptr_from_code(l.sh);
                            end
                            else
                            begin
                                ack = 1'b1;
                                next_l.iss_code = l.code;
                                next_l.iss_param = l.sh;
                                next_l.cmd_tgl = ~l.cmd_tgl;
                                next_l.ptr = (l.code == WRITE_CONFIG_CMD) ? PTR_CONFIG : PTR_STATUS;
                            end
                        end
                        else
                        begin
                            ack = 1'b0;
                            next_l.idx = 2'h2;
                        end
                        // Low over the whole ack pulse, or released on refusal
                        next_l.sda_oe = ack;
                        next_l.st = ack ? L_RX_ACK : L_IGNORE;
                    end
                end
                L_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_l.cnt = '0;
                        if (l.rw)
                        begin
                            // First read bit placed at the ack pulse's falling edge
                            next_l.sda_oe = ~s.rd_byte[7];
                            next_l.sh = {s.rd_byte[6:0], 1'b0};
                            next_l.st = L_TX;
                        end
                        else
                        begin
                            next_l.sda_oe = 1'b0;
                            next_l.st = L_RX;
                        end
                    end
                end
                L_TX:
                begin
                    if (scl_rise)
                        next_l.cnt = l.cnt + 4'h1;
                    if (scl_fall)
                    begin
                        if (l.cnt == ACK_SLOT_CNT)
                        begin
                            next_l.sda_oe = 1'b0;
                            next_l.st = L_TX_ACK;
                            // Refresh the snapshot while the master acknowledges
                            next_l.rd_req_tgl = ~l.rd_req_tgl;
                        end
                        else
                        begin
                            next_l.sda_oe = ~l.sh[7];
                            next_l.sh = {l.sh[6:0], 1'b0};
                        end
                    end
                end
                L_TX_ACK:
                begin
                    if (scl_rise)
                        next_l.master_ack = ~sda_s;
                    if (scl_fall)
                    begin
                        next_l.cnt = '0;
                        if (l.master_ack)
                        begin
                            next_l.sda_oe = ~s.rd_byte[7];
                            next_l.sh = {s.rd_byte[6:0], 1'b0};
                            next_l.st = L_TX;
                        end
                        else
                        begin
                            next_l.sda_oe = 1'b0;
                            next_l.st = L_IGNORE;
                        end
                    end
                end
                L_IGNORE:
                begin
                    next_l.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            l <= LINK_RESET;
        else
            l <= next_l;
    end

    // System domain: command hand-off and register snapshot
    always_comb
    begin
        next_s = s;
        next_s.cmd.valid = 1'b0;
        if (cmd_tgl_s != s.cmd_seen)
        begin
            // Issue registers stay still long after their toggle
            next_s.cmd_seen = cmd_tgl_s;
            next_s.cmd.valid = 1'b1;
            next_s.cmd.code = l.iss_code;
            next_s.cmd.param = l.iss_param;
        end
        if (rd_req_s != s.rd_seen)
        begin
            next_s.rd_seen = rd_req_s;
            unique case (l.ptr)
                PTR_STATUS: next_s.rd_byte = regs_i.status;
                PTR_DATA: next_s.rd_byte = regs_i.data;
                PTR_CONFIG: next_s.rd_byte = regs_i.config_val;
                default: next_s.rd_byte = regs_i.status;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            s <= '0;
        else
            s <= next_s;
    end

    assign scl_o = l.scl_out;
    assign scl_oe_o = l.scl_oe;
    assign sda_o = l.sda_out;
    assign sda_oe_o = l.sda_oe;
    assign bus_idle_o = l.idle;
    assign cmd_o = s.cmd;

endmodule // i2c_command_front_end

// file: dv/i2c_front_asserts.sv
// Port checks of the two-wire command front end.
// Assumes binding to i2c_command_front_end; both clocks share arst_n_i.
`timescale 1ns/1ps
module i2c_front_asserts
    import i2c_front_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic line_busy_flag_i,
    input wire cmd_t cmd_o,
    input wire logic bus_idle_o
);
    no_clock_drive_a: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
        !scl_oe_o && !scl_o && !sda_o)
        else $error("device drives SCL or a high level");
    idle_no_drive_a: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
        sda_oe_o |-> !bus_idle_o)
        else $error("SDA driven while bus idle");
    start_clears_idle_a: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
        scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:8] !bus_idle_o)
        else $error("start not detected");
    stop_sets_idle_a: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
        scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:8] bus_idle_o)
        else $error("stop not detected");
    drive_change_low_a: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
        $changed(sda_oe_o) |-> !scl_i)
        else $error("SDA drive changed while SCL high");
    ack_hold_a: assert property (@(posedge link_clk_i) disable iff (!arst_n_i)
        sda_oe_o && $rose(scl_i) |-> sda_oe_o[*4])
        else $error("SDA low not held over SCL high");
    cmd_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        cmd_o.valid |=> !cmd_o.valid)
        else $error("command valid longer than one cycle");
    cmd_hold_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        !cmd_o.valid |-> $stable(cmd_o.code) && $stable(cmd_o.param))
        else $error("command fields changed without valid");
    cmd_known_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        cmd_o.valid |-> cmd_o.code inside {8'hf0, 8'hd2, 8'hb4, 8'ha5, 8'h96, 8'h87, 8'h78})
        else $error("unknown command issued");
    busy_refuse_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        cmd_o.valid && cmd_o.code inside {8'hb4, 8'ha5, 8'h96, 8'h87, 8'h78} |-> !line_busy_flag_i)
        else $error("line command issued while busy");
endmodule // i2c_front_asserts

bind i2c_command_front_end i2c_front_asserts chk_i (.sys_clk_i, .arst_n_i, .link_clk_i, .scl_i, .scl_o, .scl_oe_o,
    .sda_i, .sda_o, .sda_oe_o, .line_busy_flag_i, .cmd_o, .bus_idle_o);

// file: dv/i2c_master_model.sv
// Two-wire bus master model: drives SCL and its share of SDA.
// Assumes a pull-up on SDA; the wired level comes back on sda_i.
`timescale 1ns/1ps
module i2c_master_model #(
    parameter int HALF = 640
)
(
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // One pulse; data set while SCL low, sampled at end of high
    task automatic bit_cyc(input logic b, output logic s);
        #(HALF / 4) sda_o = b;
        #(HALF * 3 / 4) scl_o = 1'b1;
        #HALF s = sda_i;
        scl_o = 1'b0;
    endtask
    task automatic start();
        if (!scl_o)
        begin
            #(HALF / 4) sda_o = 1'b1;
            #HALF scl_o = 1'b1;
            #HALF;
        end
        sda_o = 1'b0;
        #HALF scl_o = 1'b0;
    endtask
    task automatic stop();
        #(HALF / 4) sda_o = 1'b0;
        #HALF scl_o = 1'b1;
        #HALF sda_o = 1'b1;
        #HALF;
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_cyc(d[i], s);
        end
        bit_cyc(1'b1, ack);
    endtask
    task automatic rd(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_cyc(1'b1, d[i]);
        end
        bit_cyc(mack, s);
    endtask
endmodule // i2c_master_model

// file: dv/test_i2c_command_front_end.sv
// Self-checking bench for the two-wire command front end.
// Assumes the package defaults and the master model on SCL/SDA.
`timescale 1ns/1ps
module test_i2c_command_front_end
    import i2c_front_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic link_clk = 1'b0;
    logic arst_n = 1'b0;
    logic busy = 1'b0;
    logic [1:0] pins = 2'h1;
    reg_view_t regs = 24'h5a3c81;
    logic scl_m;
    logic sda_m;
    logic sda_oe;
    logic bus_idle;
    wire logic sda_w = sda_m & ~sda_oe;
    cmd_t cmd;
    cmd_t last;
    int n_fail = 0;
    int n_compared = 0;
    int n_cmd = 0;
    logic [31:0] seed = 32'h59;
    logic [7:0] codes [7] = '{DEVICE_RESET_CMD, WRITE_CONFIG_CMD, LINE_RESET_CMD, LINE_WRITE_BYTE_CMD,
        LINE_READ_BYTE_CMD, LINE_SINGLE_BIT_CMD, LINE_TRIPLET_CMD};

    always #12.5 sys_clk_i = ~sys_clk_i;
    always #32 link_clk = ~link_clk;

    i2c_master_model m (.sda_i(sda_w), .scl_o(scl_m), .sda_o(sda_m));
    i2c_command_front_end uut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n), .link_clk_i(link_clk), .scl_i(scl_m),
        .scl_o(), .scl_oe_o(), .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .addr_select_pin_low_i(pins[0]),
        .addr_select_pin_high_i(pins[1]), .line_busy_flag_i(busy), .regs_i(regs), .cmd_o(cmd),
        .bus_idle_o(bus_idle));

    always @(posedge sys_clk_i)
    begin
        if (cmd.valid === 1'b1)
        begin
            n_cmd <= n_cmd + 1;
            last <= cmd;
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic np(input logic [7:0] c);
        return c inside {WRITE_CONFIG_CMD, POINTER_SELECT_CMD, LINE_WRITE_BYTE_CMD, LINE_SINGLE_BIT_CMD,
            LINE_TRIPLET_CMD};
    endfunction
    function automatic logic [7:0] adr(input logic rw);
        return {SLAVE_ADDR_HI_DEF, pins, rw};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wcmd(input logic [7:0] c, input logic [7:0] p, input logic ea, input logic ep, input logic rs);
        logic a;
        int n0;
        logic iss;
        n0 = n_cmd;
        iss = ea && (!np(c) || ep) && c != POINTER_SELECT_CMD;
        m.start();
        m.wr(adr(1'b0), a);
        chk(a, 1'b0);
        m.wr(c, a);
        chk(a, !ea);
        if (np(c))
        begin
            m.wr(p, a);
            chk(a, !ep);
        end
        m.wr(8'(rnd()), a);
        chk(a, 1'b1);
        if (!rs)
            m.stop();
        chk(n_cmd - n0, iss);
        if (iss)
        begin
            chk(last.code, c);
            if (np(c))
                chk(last.param, p);
        end
    endtask
    task automatic rdreg(input logic [7:0] exp, input int n);
        logic a;
        logic [7:0] d;
        m.start();
        m.wr(adr(1'b1), a);
        chk(a, 1'b0);
        for (int i = 1; i <= n; i++)
        begin
            m.rd(i == n, d);
            chk(d, exp);
        end
        // Let the device react to the master's refusal before looking
        repeat (8) @(posedge link_clk);
        chk(sda_oe, 1'b0);
        m.stop();
    endtask

    initial
    begin
        logic a;
        logic [7:0] c;
        repeat (4) @(posedge sys_clk_i);
        #1 arst_n = 1'b1;
        for (int i = 0; i < 200 && bus_idle !== 1'b1; i++)
            @(posedge sys_clk_i);
        chk(bus_idle, 1'b1);
        for (int k = 0; k < 2; k++)
        begin
            m.start();
            m.wr(adr(1'b0) ^ (k ? 8'h02 : 8'h80), a);
            chk(a, 1'b1);
            m.stop();
        end
        foreach (codes[i])
        begin
            @(posedge sys_clk_i);
            #1 pins = 2'(rnd());
            regs = reg_view_t'(24'(rnd()));
            wcmd(codes[i], 8'(rnd()), 1'b1, 1'b1, 1'b0);
            rdreg(codes[i] == WRITE_CONFIG_CMD ? regs.config_val : regs.status, 2 + i % 2);
        end
        @(posedge sys_clk_i);
        #1 busy = 1'b1;
        foreach (codes[i])
            wcmd(codes[i], 8'(rnd()), i < 2, i < 2, 1'b0);
        @(posedge sys_clk_i);
        #1 busy = 1'b0;
        c = 8'(rnd());
        for (int k = 0; k < 8 && (c inside {codes} || c == POINTER_SELECT_CMD); k++)
            c = 8'(rnd());
        wcmd(c, 8'h00, 1'b0, 1'b0, 1'b0);
        wcmd(POINTER_SELECT_CMD, CONFIG_PTR_CODE, 1'b1, 1'b1, 1'b1);
        rdreg(regs.config_val, 3);
        wcmd(POINTER_SELECT_CMD, 8'he5, 1'b1, 1'b0, 1'b0);
        wcmd(POINTER_SELECT_CMD, DATA_PTR_CODE_DEF, 1'b1, 1'b1, 1'b0);
        rdreg(regs.data, 2);
        wcmd(POINTER_SELECT_CMD, STATUS_PTR_CODE_DEF, 1'b1, 1'b1, 1'b1);
        rdreg(regs.status, 1);
        results();
    end
endmodule // test_i2c_command_front_end
